/* dv/ciag_properties.sv */
// checker of the acknowledge handshake on the joining interface
// assumes the bench instantiates it beside the interface
`timescale 1ns/1ps
module ciag_properties
	import ciag_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic maskable_interrupt_request,
	input wire logic interrupt_acknowledge_n,
	input wire logic controller_register_select,
	input wire logic ready_n,
	input wire logic [CIAG_VEC_W-1:0] vector,
	input wire logic vector_valid
);
	wire a = interrupt_acknowledge_n;
	wire s = controller_register_select;
	wire r = ready_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_wait; $fell(a) |-> r ##[1:20] !r; endproperty
	a_wait: assert property (p_wait) else $error("ready without wait");
	property p_pulse; !r |=> r; endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_gap; $rose(a) && !$past(s) |-> a[*4]; endproperty
	a_gap: assert property (p_gap) else $error("idle gap short");
	property p_hold; !a && r |=> !a; endproperty
	a_hold: assert property (p_hold) else $error("ack dropped early");
	property p_two; $fell(a) && !s |-> ##[5:30] ($fell(a) && s); endproperty
	a_two: assert property (p_two) else $error("no second ack");
	property p_inack; !r |-> !a; endproperty
	a_inack: assert property (p_inack) else $error("ready outside ack");
	property p_vec; vector_valid |-> vector[7:3] == CIAG_VEC_BASE[7:3]; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_sel; $rose(vector_valid) |-> !a && s; endproperty
	a_sel: assert property (p_sel) else $error("vector outside ack2");
	property p_stab; !r && s |-> vector_valid && $stable(vector); endproperty
	a_stab: assert property (p_stab) else $error("vector unstable");
	property p_req; $fell(a) && !s |-> $past(maskable_interrupt_request); endproperty
	a_req: assert property (p_req) else $error("ack without request");
endmodule : ciag_properties

/* dv/tb_cascaded_interrupt_ack_glue.sv */
// self-checking bench joining both ends through the interface
// assumes a 10 MHz clock and inputs driven at the falling edge
`timescale 1ns/1ps
module tb_cascaded_interrupt_ack_glue;
	import ciag_pkg::*;
	logic clk = 1'b0;
	logic rst_b, instr_boundary, io_recovery_hold;
	logic table_index_valid_q, busy_q, ack_strobe_n_q;
	logic [7:0] irq_in, table_index_q;
	logic [2:0] cascade_addr_q;
	int error_cnt = 0;
	int checks_done = 0;
	ciag_if bus();
	ciag_cpu_end ciag_cpu_end_i (.clk(clk), .rst_b(rst_b), .bus(bus),
		.instr_boundary(instr_boundary), .table_index_q(table_index_q),
		.table_index_valid_q(table_index_valid_q), .busy_q(busy_q));
	ciag_ctrl_end ciag_ctrl_end_i (.clk(clk), .rst_b(rst_b), .bus(bus), .irq_in(irq_in),
		.io_recovery_hold(io_recovery_hold), .cascade_addr_q(cascade_addr_q),
		.ack_strobe_n_q(ack_strobe_n_q));
	ciag_properties ciag_properties_i (.clk(clk), .rst_b(rst_b),
		.maskable_interrupt_request(bus.maskable_interrupt_request),
		.interrupt_acknowledge_n(bus.interrupt_acknowledge_n),
		.controller_register_select(bus.controller_register_select),
		.ready_n(bus.ready_n), .vector(bus.vector), .vector_valid(bus.vector_valid));
	task automatic final_report();
		if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic svc(input logic [7:0] rq, input int hold, input logic [2:0] idx);
		int n;
		n = 0;
		irq_in = rq;
		io_recovery_hold = (hold > 0);
		repeat (6) @(negedge clk);
		chk(busy_q, 1'b0);
		instr_boundary = 1'b1;
		repeat (hold) @(negedge clk);
		chk(ack_strobe_n_q, 1'b1);
		chk(bus.ready_n, 1'b1);
		io_recovery_hold = 1'b0;
		while (table_index_valid_q !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 60) begin
				error_cnt++;
				final_report();
			end
		end
		chk(table_index_q, CIAG_VEC_BASE | idx);
		chk(cascade_addr_q, idx);
		irq_in = 8'h00;
		instr_boundary = 1'b0;
		repeat (4) @(negedge clk);
		chk(busy_q, 1'b0);
	endtask : svc
	initial begin
		clk = 1'b0;
		forever #(CIAG_CLK_PERIOD_NS / 2) clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		irq_in = 8'h00;
		instr_boundary = 1'b0;
		io_recovery_hold = 1'b0;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 8; i++) svc(8'h80 | (8'h01 << i), 0, i[2:0]);
		svc(8'h24, 5, 3'h2);
		final_report();
	end
endmodule : tb_cascaded_interrupt_ack_glue

/* src/ciag_cpu_end.sv */
// processor end: takes requests at instruction boundaries, runs two ack cycles
// assumes the controller end paces each ack with ready_n
// How it works
// RQ1: bridge steers bytes between wide and narrow buses; code has no byte steering, vector is taken as one byte
// RQ2: requests taken only at instruction boundaries
// RQ3: eight-bit vector indexes the service table
// RQ4: vector space holds 256 distinct sources
// RQ5: glue derives chip select and strobes; code derives only ack_strobe_n_q, no chip select
// RQ6: lone controller is cascade master
// RQ7: register select follows cpu address bit two
// RQ8: controller output drives maskable request
// RQ9: two back-to-back ack cycles per request
// RQ10: each ack cycle has a wait state
// RQ11: four idle clocks between ack cycles
// RQ12: first ack freezes request inputs
// RQ13: master drives cascade address in first ack
// RQ14: only chosen slave drives vector; code has no slaves, the controller end drives vector itself
// RQ15: ack strobe gates vector onto bus; code drives vector from vec_q at all times, ack_strobe_n_q gates nothing
// RQ16: controller resolves priority, one request out
// RQ17: two levels give at most 64 inputs; code has one controller level with 8 inputs
// RQ18: third polled tier feeds second tier; code has no third tier
// RQ19: third tier found by polling status; code has no third tier and no status polling
// RQ20: strobes stay off during recovery hold
// RQ21: ready only after wait state, vector stable
`timescale 1ns/1ps
module ciag_cpu_end
	import ciag_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	ciag_if.cpu bus,
	input wire logic instr_boundary,
	output logic [CIAG_VEC_W-1:0] table_index_q,
	output logic table_index_valid_q,
	output logic busy_q
);
	typedef enum logic [2:0] {CIAG_IDLE, CIAG_ACK1, CIAG_GAP, CIAG_ACK2, CIAG_DONE} ciag_state_t;
	ciag_state_t state_q;
	logic take_req;
	logic ack1_end;
	logic gap_end;
	logic ack2_end;
	logic t2_q;
	logic [CIAG_WAIT_W-1:0] gap_q;
	logic interrupt_acknowledge_n_q;
	logic cpu_address_bit_two_q;

	// request taken only in idle at a boundary
	assign take_req = (state_q == CIAG_IDLE) && bus.maskable_interrupt_request
		&& instr_boundary; // RQ2
	// ready counts only from the second clock of an ack cycle
	assign ack1_end = (state_q == CIAG_ACK1) && t2_q && !bus.ready_n;
	assign gap_end = (state_q == CIAG_GAP) && (gap_q == 3'h1);
	assign ack2_end = (state_q == CIAG_ACK2) && t2_q && !bus.ready_n;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= CIAG_IDLE;
		end else begin
			unique case (state_q)
				CIAG_IDLE: begin
					if (take_req) begin
						state_q <= CIAG_ACK1; // RQ9
					end
				end
				CIAG_ACK1: begin
					if (ack1_end) begin
						state_q <= CIAG_GAP;
					end
				end
				CIAG_GAP: begin
					if (gap_end) begin
						state_q <= CIAG_ACK2; // RQ9
					end
				end
				CIAG_ACK2: begin
					if (ack2_end) begin
						state_q <= CIAG_DONE;
					end
				end
				CIAG_DONE: begin
					state_q <= CIAG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			t2_q <= 1'b0;
		end else if (interrupt_acknowledge_n_q || ack1_end || ack2_end) begin
			t2_q <= 1'b0;
		end else begin
			t2_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_q <= '0;
		end else if (ack1_end) begin
			gap_q <= CIAG_IDLE_CNT; // RQ11
		end else if (gap_q != '0) begin
			gap_q <= gap_q - 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			interrupt_acknowledge_n_q <= 1'b1;
		end else if (take_req || gap_end) begin
			interrupt_acknowledge_n_q <= 1'b0; // RQ9
		end else if (ack1_end || ack2_end) begin
			interrupt_acknowledge_n_q <= 1'b1; // RQ21
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_address_bit_two_q <= 1'b0;
		end else if (gap_end) begin
			cpu_address_bit_two_q <= 1'b1; // RQ7
		end else if (take_req || ack2_end) begin
			cpu_address_bit_two_q <= 1'b0; // RQ7
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			table_index_q <= CIAG_VEC_RESET;
		end else if (ack2_end && bus.vector_valid) begin
			table_index_q <= bus.vector; // RQ1 RQ3 RQ4
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			table_index_valid_q <= 1'b0;
		end else begin
			table_index_valid_q <= ack2_end && bus.vector_valid; // RQ3
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_q != CIAG_IDLE) || take_req;
		end
	end

	assign bus.interrupt_acknowledge_n = interrupt_acknowledge_n_q;
	assign bus.controller_register_select = cpu_address_bit_two_q;
endmodule : ciag_cpu_end

/* src/ciag_ctrl_end.sv */
// controller end: master with priority resolve, wait state and vector drive
// assumes the processor end keeps the idle gap between ack cycles
`timescale 1ns/1ps
module ciag_ctrl_end
	import ciag_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	ciag_if.ctrl bus,
	input wire logic [CIAG_REQ_W-1:0] irq_in,
	input wire logic io_recovery_hold,
	output logic [CIAG_CASCADE_W-1:0] cascade_addr_q,
	output logic ack_strobe_n_q
);
	logic [CIAG_REQ_W-1:0] irq_s1_q;
	logic [CIAG_REQ_W-1:0] irq_s2_q;
	logic [CIAG_REQ_W-1:0] frozen_q;
	logic int_q;
	logic rdy_n_q;
	logic vec_valid_q;
	logic [CIAG_VEC_W-1:0] vec_q;
	logic [CIAG_WAIT_W-1:0] wait_q;
	logic in_cycle_q;
	logic ack_live;
	logic [CIAG_CASCADE_W-1:0] top_idx;
	logic any_req;

	assign ack_live = !bus.interrupt_acknowledge_n && !io_recovery_hold; // RQ20

	always_comb begin
		top_idx = '0;
		for (int i = CIAG_REQ_W - 1; i >= 0; i--) begin
			if (frozen_q[i]) begin
				top_idx = CIAG_CASCADE_W'(i); // RQ16
			end
		end
	end

	assign any_req = |irq_s2_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_s1_q <= '0;
			irq_s2_q <= '0;
			int_q <= 1'b0;
		end else begin
			irq_s1_q <= irq_in;
			irq_s2_q <= irq_s1_q;
			int_q <= any_req; // RQ8 RQ18
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_cycle_q <= 1'b0;
			wait_q <= '0;
			rdy_n_q <= 1'b1;
			frozen_q <= '0;
			cascade_addr_q <= CIAG_CASCADE_RESET;
			vec_q <= CIAG_VEC_RESET;
			vec_valid_q <= 1'b0;
			ack_strobe_n_q <= 1'b1;
		end else begin
			rdy_n_q <= 1'b1;
			ack_strobe_n_q <= !ack_live; // RQ5 RQ15
			if (bus.interrupt_acknowledge_n) begin
				in_cycle_q <= 1'b0;
				vec_valid_q <= 1'b0;
			end else if (ack_live && !in_cycle_q) begin
				in_cycle_q <= 1'b1;
				wait_q <= CIAG_WAIT_CNT; // RQ10
				if (!bus.controller_register_select) begin
					frozen_q <= irq_s2_q; // RQ12
				end else begin
					vec_q <= CIAG_VEC_BASE | {5'h00, cascade_addr_q}; // RQ14 RQ19
					vec_valid_q <= 1'b1;
				end
			end else if (in_cycle_q && wait_q != '0) begin
				wait_q <= wait_q - 3'h1;
				if (!bus.controller_register_select) begin
					cascade_addr_q <= top_idx; // RQ13 RQ6 RQ17
				end
				if (wait_q == 3'h1) begin
					rdy_n_q <= 1'b0; // RQ21
				end
			end
		end
	end

	assign bus.maskable_interrupt_request = int_q;
	assign bus.ready_n = rdy_n_q;
	assign bus.vector = vec_q;
	assign bus.vector_valid = vec_valid_q;
endmodule : ciag_ctrl_end

/* src/ciag_if.sv */
// interface joining the processor side and the controller side
// assumes both ends on clk; active-low strobes end in _n
`timescale 1ns/1ps
interface ciag_if;
	import ciag_pkg::*;
	logic maskable_interrupt_request;
	logic interrupt_acknowledge_n;
	logic controller_register_select;
	logic ready_n;
	logic [CIAG_VEC_W-1:0] vector;
	logic vector_valid;
	modport cpu (
		input maskable_interrupt_request,
		output interrupt_acknowledge_n,
		output controller_register_select,
		input ready_n,
		input vector,
		input vector_valid
	);
	modport ctrl (
		output maskable_interrupt_request,
		input interrupt_acknowledge_n,
		input controller_register_select,
		output ready_n,
		output vector,
		output vector_valid
	);
endinterface : ciag_if

/* src/ciag_pkg.sv */
// package of shared constants for the cascaded interrupt acknowledge glue
// assumes one 10 MHz clock shared by both ends
package ciag_pkg;
	localparam int CIAG_DATA_W = 32;
	localparam int CIAG_VEC_W = 8;
	localparam int CIAG_NUM_VECTORS = 256;
	localparam int CIAG_CLK_PERIOD_NS = 100;
	localparam int CIAG_ACK_WAIT_STATES = 1;
	localparam int CIAG_IDLE_BETWEEN_ACKS = 4;
	localparam int CIAG_WAIT_W = 3;
	localparam int CIAG_CASCADE_W = 3;
	localparam int CIAG_REQ_W = 8;
	localparam logic [CIAG_WAIT_W-1:0] CIAG_WAIT_CNT = CIAG_WAIT_W'(CIAG_ACK_WAIT_STATES);
	localparam logic [CIAG_WAIT_W-1:0] CIAG_IDLE_CNT = CIAG_WAIT_W'(CIAG_IDLE_BETWEEN_ACKS);
	localparam logic [CIAG_VEC_W-1:0] CIAG_VEC_BASE = 8'h20;
	localparam logic [CIAG_VEC_W-1:0] CIAG_VEC_RESET = 8'h00;
	localparam logic [CIAG_CASCADE_W-1:0] CIAG_CASCADE_RESET = 3'h0;
endpackage : ciag_pkg
